/* File: design/isd_defs.vh */
/*
 * Constants for the initial speed detect settings register: address,
 * reset value, field positions and the reset values of the decoded thresholds.
 * Assumes inclusion by bare name from the design files under design/.
 */
`ifndef ISD_DEFS_VH
`define ISD_DEFS_VH

`define ISD_ADDR_W 8
`define ISD_DATA_W 32
`define ISD_SETTINGS_ADDR 8'h80
`define ISD_SETTINGS_RESET 32'h00000000
`define ISD_READ_ZERO 32'h00000000
`define ISD_SPEED_PERMILLE_RESET 10'h032
`define ISD_EMF_MV_RESET 11'h032

`define ISD_BIT_RSVD 31
`define ISD_BIT_DETECT 30
`define ISD_BIT_BRAKE 29
`define ISD_BIT_COAST 28
`define ISD_BIT_BACKWARD 27
`define ISD_BIT_RESYNC 26
`define ISD_RESYNC_SPD_HI 25
`define ISD_RESYNC_SPD_LO 22
`define ISD_BIT_BRAKE_SIDE 21
`define ISD_BIT_BRAKE_EXIT 20
`define ISD_BRK_CURR_HI 19
`define ISD_BRK_CURR_LO 17
`define ISD_BRK_TIME_HI 16
`define ISD_BRK_TIME_LO 13
`define ISD_COAST_TIME_HI 12
`define ISD_COAST_TIME_LO 9
`define ISD_STAT_EMF_HI 8
`define ISD_STAT_EMF_LO 6
`define ISD_HANDOFF_HI 5
`define ISD_HANDOFF_LO 2
`define ISD_OPEN_CURR_HI 1
`define ISD_OPEN_CURR_LO 0

`endif

/* File: design/isd_code_lut.v */
/*
 * Translates the two threshold codes of the settings register into
 * engineering units: resync speed in tenths of a percent of maximum
 * speed, and the stationary back-EMF level in millivolts.
 * Assumes registered code inputs; the outputs are purely combinational.
 */
`timescale 1ns/1ps
module isd_code_lut (
    // Codes
    input wire [3:0] speed_code_in,
    input wire [2:0] emf_code_in,
    // Decoded values
    output reg [9:0] speed_permille_out,
    output reg [10:0] emf_mv_out
);
    always @* begin
        case (speed_code_in)
            4'h0: speed_permille_out = 10'h032;
            4'h1: speed_permille_out = 10'h064;
            4'h2: speed_permille_out = 10'h096;
            4'h3: speed_permille_out = 10'h0C8;
            4'h4: speed_permille_out = 10'h0FA;
            4'h5: speed_permille_out = 10'h12C;
            4'h6: speed_permille_out = 10'h15E;
            4'h7: speed_permille_out = 10'h190;
            4'h8: speed_permille_out = 10'h1C2;
            4'h9: speed_permille_out = 10'h1F4;
            4'hA: speed_permille_out = 10'h226;
            4'hB: speed_permille_out = 10'h258;
            4'hC: speed_permille_out = 10'h2BC;
            4'hD: speed_permille_out = 10'h320;
            4'hE: speed_permille_out = 10'h384;
            default: speed_permille_out = 10'h3E8;
        endcase
    end

    always @* begin
        case (emf_code_in)
            3'h0: emf_mv_out = 11'h032;
            3'h1: emf_mv_out = 11'h04B;
            3'h2: emf_mv_out = 11'h064;
            3'h3: emf_mv_out = 11'h0FA;
            3'h4: emf_mv_out = 11'h1F4;
            3'h5: emf_mv_out = 11'h2EE;
            3'h6: emf_mv_out = 11'h3E8;
            default: emf_mv_out = 11'h5DC;
        endcase
    end
endmodule

/* File: design/isd_settings.v */
/*
 * Initial speed detect settings register with its decoded control outputs
 * toward the start-up sequencer.
 * Assumes a single 100 MHz clock, synchronous active-high reset and a
 * master that never issues read and write strobes together.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "isd_defs.vh"
module isd_settings (
    // Clock and reset
    input wire clk_in,
    input wire sys_rst_in,
    // Register port
    input wire [`ISD_ADDR_W-1:0] reg_addr_in,
    input wire [`ISD_DATA_W-1:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [`ISD_DATA_W-1:0] reg_rdata_out,
    // Enables toward the sequencer
    output reg speed_detect_on_out,
    output reg brake_on_out,
    output reg tristate_coast_on_out,
    output reg backward_drive_on_out,
    output reg forward_resync_on_out,
    // Mode selects and raw codes
    output reg [3:0] resync_min_speed_sel_out,
    output reg brake_switch_side_sel_out,
    output reg brake_exit_condition_sel_out,
    output reg [2:0] brake_current_sel_out,
    output reg [3:0] brake_time_sel_out,
    output reg [3:0] coast_time_sel_out,
    output reg [2:0] stationary_emf_level_sel_out,
    output reg [3:0] handoff_speed_sel_out,
    output reg [1:0] open_loop_current_sel_out,
    // Decoded thresholds
    output reg [9:0] resync_min_speed_permille_out,
    output reg [10:0] stationary_emf_mv_out
);
    reg [`ISD_DATA_W-1:0] settings_q;
    reg [`ISD_DATA_W-1:0] settings_d;
    wire [9:0] speed_permille;
    wire [10:0] emf_mv;

    function hit_settings;
        input [`ISD_ADDR_W-1:0] addr;
        begin
            hit_settings = (addr == `ISD_SETTINGS_ADDR);
        end
    endfunction

    // Whole-word writes only; the port has no byte enables.
    always @* begin
        settings_d = settings_q;
        if (reg_wr_in && hit_settings(reg_addr_in)) begin
            settings_d = reg_wdata_in;
        end
    end

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            settings_q <= `ISD_SETTINGS_RESET;
        end else begin
            settings_q <= settings_d;
        end
    end

    // Unmapped reads return zero so software can probe the map safely.
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= `ISD_READ_ZERO;
        end else if (reg_rd_in && hit_settings(reg_addr_in)) begin
            reg_rdata_out <= settings_q;
        end else begin
            reg_rdata_out <= `ISD_READ_ZERO;
        end
    end

    isd_code_lut u_lut (
        .speed_code_in(settings_q[`ISD_RESYNC_SPD_HI:`ISD_RESYNC_SPD_LO]),
        .emf_code_in(settings_q[`ISD_STAT_EMF_HI:`ISD_STAT_EMF_LO]),
        .speed_permille_out(speed_permille),
        .emf_mv_out(emf_mv)
    );

    // Outputs trail the register by one cycle so every output is a flop.
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            speed_detect_on_out <= 1'h0;
            brake_on_out <= 1'h0;
            tristate_coast_on_out <= 1'h0;
            backward_drive_on_out <= 1'h0;
            forward_resync_on_out <= 1'h0;
            resync_min_speed_sel_out <= 4'h0;
            brake_switch_side_sel_out <= 1'h0;
            brake_exit_condition_sel_out <= 1'h0;
            brake_current_sel_out <= 3'h0;
            brake_time_sel_out <= 4'h0;
            coast_time_sel_out <= 4'h0;
            stationary_emf_level_sel_out <= 3'h0;
            handoff_speed_sel_out <= 4'h0;
            open_loop_current_sel_out <= 2'h0;
            resync_min_speed_permille_out <= `ISD_SPEED_PERMILLE_RESET;
            stationary_emf_mv_out <= `ISD_EMF_MV_RESET;
        end else begin
            speed_detect_on_out <= settings_q[`ISD_BIT_DETECT];
            brake_on_out <= settings_q[`ISD_BIT_BRAKE];
            tristate_coast_on_out <= settings_q[`ISD_BIT_COAST];
            backward_drive_on_out <= settings_q[`ISD_BIT_BACKWARD];
            forward_resync_on_out <= settings_q[`ISD_BIT_RESYNC];
            resync_min_speed_sel_out <= settings_q[`ISD_RESYNC_SPD_HI:`ISD_RESYNC_SPD_LO];
            brake_switch_side_sel_out <= settings_q[`ISD_BIT_BRAKE_SIDE];
            brake_exit_condition_sel_out <= settings_q[`ISD_BIT_BRAKE_EXIT];
            brake_current_sel_out <= settings_q[`ISD_BRK_CURR_HI:`ISD_BRK_CURR_LO];
            brake_time_sel_out <= settings_q[`ISD_BRK_TIME_HI:`ISD_BRK_TIME_LO];
            coast_time_sel_out <= settings_q[`ISD_COAST_TIME_HI:`ISD_COAST_TIME_LO];
            stationary_emf_level_sel_out <= settings_q[`ISD_STAT_EMF_HI:`ISD_STAT_EMF_LO];
            handoff_speed_sel_out <= settings_q[`ISD_HANDOFF_HI:`ISD_HANDOFF_LO];
            open_loop_current_sel_out <= settings_q[`ISD_OPEN_CURR_HI:`ISD_OPEN_CURR_LO];
            resync_min_speed_permille_out <= speed_permille;
            stationary_emf_mv_out <= emf_mv;
        end
    end
endmodule

/* File: sim/isd_settings_assertions.sv */
/* Checker for the settings register: read path, write path and decoded outputs.
   Assumes it is bound to isd_settings, with one clock and a synchronous reset. */
`timescale 1ns/1ps
module isd_settings_chk (
    input logic clk_in, sys_rst_in, reg_wr_in, reg_rd_in,
    input logic [7:0] reg_addr_in,
    input logic [31:0] reg_wdata_in, reg_rdata_out,
    input logic speed_detect_on_out, brake_on_out, tristate_coast_on_out, backward_drive_on_out,
    input logic forward_resync_on_out, brake_switch_side_sel_out, brake_exit_condition_sel_out,
    input logic [3:0] resync_min_speed_sel_out, brake_time_sel_out, coast_time_sel_out, handoff_speed_sel_out,
    input logic [2:0] brake_current_sel_out, stationary_emf_level_sel_out,
    input logic [1:0] open_loop_current_sel_out,
    input logic [9:0] resync_min_speed_permille_out,
    input logic [10:0] stationary_emf_mv_out
);
    wire wr_hit = reg_wr_in && reg_addr_in == 8'h80;
    wire rd_hit = reg_rd_in && reg_addr_in == 8'h80;
    wire [30:0] ctl = {speed_detect_on_out, brake_on_out, tristate_coast_on_out, backward_drive_on_out,
        forward_resync_on_out, resync_min_speed_sel_out, brake_switch_side_sel_out, brake_exit_condition_sel_out,
        brake_current_sel_out, brake_time_sel_out, coast_time_sel_out, stationary_emf_level_sel_out,
        handoff_speed_sel_out, open_loop_current_sel_out};
    wire [3:0] sp = resync_min_speed_sel_out;
    wire [2:0] ec = stationary_emf_level_sel_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    rd_data_a: assert property (rd_hit |=> reg_rdata_out[30:0] == ctl)
        else $error("read data differs from outputs");
    rd_idle_a: assert property (!rd_hit |=> reg_rdata_out == 32'h00000000)
        else $error("read data not zero");
    wr_out_a: assert property (wr_hit |-> ##2 ctl == $past(reg_wdata_in[30:0], 2))
        else $error("outputs miss written value");
    out_hold_a: assert property (!wr_hit ##1 !wr_hit |=> $stable(ctl))
        else $error("outputs moved without write");
    write_readback_a: assert property (wr_hit ##1 rd_hit |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("read after write wrong");
    reset_value_a: assert property ($fell(sys_rst_in) |-> ctl == 31'h0 && stationary_emf_mv_out == 11'h032
        && resync_min_speed_permille_out == 10'h032 && reg_rdata_out == 32'h00000000)
        else $error("outputs not cleared by reset");
    speed_decode_a: assert property (resync_min_speed_permille_out == (sp < 4'hC ? (sp + 10'h001) * 10'h032
        : sp * 10'h064 - 10'h1F4)) else $error("speed decode wrong");
    emf_decode_a: assert property (stationary_emf_mv_out == (ec < 3'h3 ? 11'h032 + ec * 11'h019 :
        ec == 3'h7 ? 11'h5DC : (ec - 11'h002) * 11'h0FA)) else $error("emf decode wrong");
    cover property (wr_hit ##1 rd_hit);
    cover property (reg_wr_in && !wr_hit);
    cover property ($fell(sys_rst_in) ##[1:300] wr_hit);
endmodule

/* File: sim/isd_settings_tb_top.sv */
/* Random and corner-case bench for the settings register.
   Assumes the design and the checker are compiled beforehand. */
`timescale 1ns/1ps
module isd_settings_tb_top;
    logic clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, mdl = 32'h0, d;
    logic speed_detect_on_out, brake_on_out, tristate_coast_on_out, backward_drive_on_out;
    logic forward_resync_on_out, brake_switch_side_sel_out, brake_exit_condition_sel_out;
    logic [3:0] resync_min_speed_sel_out, brake_time_sel_out, coast_time_sel_out, handoff_speed_sel_out;
    logic [2:0] brake_current_sel_out, stationary_emf_level_sel_out;
    logic [1:0] open_loop_current_sel_out;
    logic [9:0] resync_min_speed_permille_out;
    logic [10:0] stationary_emf_mv_out;
    int error_cnt = 0, checked = 0, seed = 94;
    logic [9:0] spd_t [16] = '{10'h032, 10'h064, 10'h096, 10'h0C8, 10'h0FA, 10'h12C, 10'h15E, 10'h190,
        10'h1C2, 10'h1F4, 10'h226, 10'h258, 10'h2BC, 10'h320, 10'h384, 10'h3E8};
    logic [10:0] emf_t [8] = '{11'h032, 11'h04B, 11'h064, 11'h0FA, 11'h1F4, 11'h2EE, 11'h3E8, 11'h5DC};
    isd_settings dut (.*);
    task chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Every strobe is assigned once per call, so back-to-back calls never double-drive.
    task op(input logic w, r, input logic [7:0] a, input logic [31:0] v);
        reg_wr_in <= w;
        reg_rd_in <= r;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge clk_in);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        op(1, 0, a, v);
        if (a == 8'h80) mdl = v;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        op(0, 1, a, 32'h0);
        op(0, 0, 8'h00, 32'h0);
        chk("rdata", reg_rdata_out, e);
    endtask
    task check_outs;
        chk("ctl", {1'b0, speed_detect_on_out, brake_on_out, tristate_coast_on_out, backward_drive_on_out,
            forward_resync_on_out, resync_min_speed_sel_out, brake_switch_side_sel_out,
            brake_exit_condition_sel_out, brake_current_sel_out, brake_time_sel_out, coast_time_sel_out,
            stationary_emf_level_sel_out, handoff_speed_sel_out, open_loop_current_sel_out},
            {1'b0, mdl[30:0]});
        chk("speed", {22'h0, resync_min_speed_permille_out}, {22'h0, spd_t[mdl[25:22]]});
        chk("emf", {21'h0, stationary_emf_mv_out}, {21'h0, emf_t[mdl[8:6]]});
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        #20000 error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 0;
        rd(8'h80, 32'h0);
        check_outs;
        $display("test reset done");
        for (int i = 0; i < 26; i++) begin
            d = $random(seed);
            d[25:22] = i[3:0];
            d[8:6] = i[2:0];
            if (i == 24) d = 32'hFFFFFFFF;
            if (i == 25) d = 32'h80000000;
            wr(8'h80, d);
            rd(8'h80, mdl);
            check_outs;
            d = $random(seed);
            if (d[7:0] == 8'h80) d[0] = 1'b1;
            wr(d[7:0], ~mdl);
            rd(d[7:0], 32'h0);
            check_outs;
        end
        $display("test fields done");
        wr(8'h80, 32'h7FFFFFFF);
        sys_rst_in <= 1;
        op(0, 0, 8'h00, 32'h0);
        op(0, 0, 8'h00, 32'h0);
        sys_rst_in <= 0;
        mdl = 32'h0;
        rd(8'h80, 32'h0);
        check_outs;
        $display("test mid reset done");
        give_verdict;
    end
endmodule
bind isd_settings isd_settings_chk chk (.*);
